// [hw/jdop_output_proc.sv]
// Notes on behaviour
// - recall replaces settings with slot contents, or factory defaults if slot empty
// - seven preset slots, index 0 to 6
// - after recall, measurement restarts with loaded settings
// - mode picks proportional level or pass/fail level
// - proportional: lower limit gives 0 V code, upper limit 5 V code, linear between
// - proportional result above full scale saturates at 5 V code
// - pass/fail: 5 V code at or below threshold, 0 V code above
// - upper and lower limits 0.00% to 100.00%, step 0.01%
// - threshold 0.00% to 100.00%, step 0.01%
// - moving average over last N results, N from 1 to 10
// - averaged ratio feeds both modes, display and meter
// - corrected ratio = alpha times ratio plus beta percent
// - corrected jitter = alpha times jitter plus beta percent of T
// - T is 231.385/N in pulse width mode, else clock period
// - alpha 0.0001 to 9.9999, step 0.0001
// - beta signed -9.999% to 9.999%, step 0.001%
// - ratio indicator blinks while shown and count or coefficients differ from defaults
// - average indicator blinks while shown and count differs from default
// - no trigger and no result forces 5 V code
// - loss of lock forces 5 V code
// - leaving configuration applies entered values and resumes measurement
`timescale 1ns/1ps
`default_nettype none
module jdop_output_proc #(
  parameter int unsigned BLINK_CYCLES = jdop_pkg::BLINK_CYCLES
) (
  input  wire logic                clock,
  input  wire logic                srst,
  input  wire logic                meas_valid,
  input  wire jdop_pkg::jdop_meas_t meas_in,
  input  wire logic                trig_present,
  input  wire logic                lock_lost,
  input  wire jdop_pkg::jdop_func_t func_mode,
  input  wire logic [3:0]          speed_mult,
  input  wire logic [23:0]         clk_period,
  input  wire logic                cfg_apply,
  input  wire jdop_pkg::jdop_cfg_t cfg_in,
  input  wire logic                preset_store,
  input  wire logic                preset_recall,
  input  wire logic [2:0]          preset_index,
  input  wire logic                show_avg,
  output logic [11:0]              dac_code,
  output logic [15:0]              disp_ratio,
  output logic [23:0]              disp_jitter,
  output logic                     disp_valid,
  output logic                     ratio_ind_on,
  output logic                     avg_ind_on,
  output logic                     preset_load_message,
  output logic                     meas_restart,
  output jdop_pkg::jdop_cfg_t      cfg_active
);
  // out-of-range fields are clamped so downstream math never sees illegal values
  function automatic jdop_pkg::jdop_cfg_t clamp_cfg(input jdop_pkg::jdop_cfg_t c);
    jdop_pkg::jdop_cfg_t r;
    r = c;
    if (c.range_upper_limit > jdop_pkg::PCT_MAX) r.range_upper_limit = jdop_pkg::PCT_MAX;
    if (c.range_lower_limit > jdop_pkg::PCT_MAX) r.range_lower_limit = jdop_pkg::PCT_MAX;
    if (c.pass_fail_threshold > jdop_pkg::PCT_MAX) r.pass_fail_threshold = jdop_pkg::PCT_MAX;
    if (c.averaging_count < jdop_pkg::AVG_MIN) r.averaging_count = jdop_pkg::AVG_MIN;
    if (c.averaging_count > jdop_pkg::AVG_MAX) r.averaging_count = jdop_pkg::AVG_MAX;
    if (c.alpha < jdop_pkg::ALPHA_MIN) r.alpha = jdop_pkg::ALPHA_MIN;
    if (c.alpha > jdop_pkg::ALPHA_MAX) r.alpha = jdop_pkg::ALPHA_MAX;
    if (c.beta > jdop_pkg::BETA_MAX) r.beta = jdop_pkg::BETA_MAX;
    if (c.beta < jdop_pkg::BETA_MIN) r.beta = jdop_pkg::BETA_MIN;
    return r;
  endfunction

  jdop_pkg::jdop_cfg_t cfg_q;
  jdop_pkg::jdop_cfg_t slot_q [jdop_pkg::SLOTS];
  logic [jdop_pkg::SLOTS-1:0] slot_valid_q;
  logic idx_ok;
  logic recall_go;
  logic restart_q;
  logic load_msg_q;

  assign idx_ok = preset_index < 3'(jdop_pkg::SLOTS);
  assign recall_go = preset_recall && idx_ok;
  assign cfg_active = cfg_q;
  assign meas_restart = restart_q;
  assign preset_load_message = load_msg_q;

  // recall takes priority over a configuration apply in the same cycle
  always_ff @(posedge clock) begin
    if (srst) begin
      cfg_q <= jdop_pkg::CFG_DEFAULT;
    end else if (recall_go) begin
      cfg_q <= slot_valid_q[preset_index] ? slot_q[preset_index] : jdop_pkg::CFG_DEFAULT;
    end else if (cfg_apply) begin
      cfg_q <= clamp_cfg(cfg_in);
    end
  end

  // slots forget their contents on reset; there is no battery here
  always_ff @(posedge clock) begin
    if (srst) begin
      slot_valid_q <= '0;
    end else if (preset_store && idx_ok) begin
      slot_q[preset_index]       <= cfg_q;
      slot_valid_q[preset_index] <= 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      restart_q  <= 1'b0;
      load_msg_q <= 1'b0;
    end else begin
      restart_q  <= recall_go || cfg_apply;
      load_msg_q <= recall_go;
    end
  end

  // history of ratios, newest at index zero
  logic [15:0] hist_q [jdop_pkg::HIST_N];
  logic [3:0]  fill_q;
  logic        stage_q;
  logic [23:0] jit_q;
  logic        have_res_q;

  // a result arriving in the restart cycle is dropped so no old setting leaks into the average
  always_ff @(posedge clock) begin
    if (srst || restart_q) begin
      fill_q  <= 4'h0;
      stage_q <= 1'b0;
    end else begin
      stage_q <= meas_valid;
      if (meas_valid && fill_q < 4'(jdop_pkg::HIST_N)) fill_q <= fill_q + 4'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (meas_valid) begin
      hist_q[0] <= meas_in.ratio;
      jit_q     <= meas_in.jitter;
      for (int i = 1; i < jdop_pkg::HIST_N; i++) hist_q[i] <= hist_q[i-1];
    end
  end

  logic [3:0]  n_eff;
  logic [19:0] win_sum;
  logic [15:0] avg_w;
  always_comb begin
    n_eff = (cfg_q.averaging_count < fill_q) ? cfg_q.averaging_count : fill_q;
    if (n_eff == 4'h0) n_eff = 4'h1;
    win_sum = '0;
    for (int i = 0; i < jdop_pkg::HIST_N; i++) begin
      if (4'(i) < n_eff) win_sum = win_sum + 20'(hist_q[i]);
    end
    avg_w = 16'(win_sum / 20'(n_eff));
  end

  // correction in 0.001% units, then back to 0.01%; negative clamps to zero
  logic signed [47:0] corr_milli;
  logic [15:0]        corr_w;
  always_comb begin
    corr_milli = 48'(longint'(cfg_q.alpha) * longint'(avg_w)
      / (jdop_pkg::ALPHA_SCALE / jdop_pkg::MILLI_PER_CENTI)) + 48'(cfg_q.beta);
    if (corr_milli < 0) corr_w = 16'h0000;
    else if (corr_milli / 48'(jdop_pkg::MILLI_PER_CENTI) > 48'hffff) corr_w = 16'hffff;
    else corr_w = 16'(corr_milli / 48'(jdop_pkg::MILLI_PER_CENTI));
  end

  logic [23:0]        period_w;
  logic signed [63:0] jcorr;
  logic [23:0]        jcorr_w;
  always_comb begin
    if (func_mode == jdop_pkg::JDOP_PULSE_WIDTH_MODE) begin
      period_w = 24'(jdop_pkg::PW_PERIOD_MILLI / longint'((speed_mult == 4'h0) ? 4'h1 : speed_mult));
    end else begin
      period_w = clk_period;
    end
    jcorr = longint'(cfg_q.alpha) * longint'(jit_q) / jdop_pkg::ALPHA_SCALE
      + longint'(cfg_q.beta) * longint'(period_w) / jdop_pkg::BETA_SCALE;
    if (jcorr < 0) jcorr_w = 24'h000000;
    else if (jcorr > 64'sh0ffffff) jcorr_w = 24'hffffff;
    else jcorr_w = 24'(jcorr);
  end

  logic [15:0] span;
  logic [11:0] prop_code;
  logic [11:0] pf_code;
  logic [11:0] new_code;
  always_comb begin
    span = (cfg_q.range_upper_limit > cfg_q.range_lower_limit)
      ? 16'(cfg_q.range_upper_limit - cfg_q.range_lower_limit) : 16'h0001;
    if (corr_w <= 16'(cfg_q.range_lower_limit)) prop_code = jdop_pkg::CODE_ZERO;
    else if (corr_w >= 16'(cfg_q.range_upper_limit)) prop_code = jdop_pkg::CODE_FULL;
    else prop_code = 12'(32'(corr_w - 16'(cfg_q.range_lower_limit))
      * 32'(jdop_pkg::CODE_FULL) / 32'(span));
    pf_code = (corr_w <= 16'(cfg_q.pass_fail_threshold))
      ? jdop_pkg::CODE_FULL : jdop_pkg::CODE_ZERO;
    new_code = (cfg_q.mode == jdop_pkg::JDOP_PASS_FAIL) ? pf_code : prop_code;
  end

  logic [11:0] calc_q;
  logic [11:0] dac_q;
  logic        force_full;
  // holding full until a fresh result keeps codes from before a restart off the pin
  assign force_full = lock_lost || !trig_present || !have_res_q;
  assign dac_code = dac_q;

  always_ff @(posedge clock) begin
    if (srst || restart_q) begin
      have_res_q <= 1'b0;
      calc_q     <= jdop_pkg::CODE_FULL;
      disp_ratio <= '0;
      disp_jitter <= '0;
      disp_valid <= 1'b0;
    end else if (stage_q) begin
      have_res_q <= 1'b1;
      calc_q     <= new_code;
      disp_ratio <= corr_w;
      disp_jitter <= jcorr_w;
      disp_valid <= 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) dac_q <= jdop_pkg::CODE_FULL;
    else dac_q <= force_full ? jdop_pkg::CODE_FULL : calc_q;
  end

  // a shared phase keeps both indicators blinking in step
  logic [31:0] blink_cnt_q;
  logic        phase_q;
  logic        avg_nondef;
  logic        any_nondef;
  assign avg_nondef = cfg_q.averaging_count != jdop_pkg::CFG_DEFAULT.averaging_count;
  assign any_nondef = avg_nondef || cfg_q.alpha != jdop_pkg::CFG_DEFAULT.alpha
    || cfg_q.beta != jdop_pkg::CFG_DEFAULT.beta;

  always_ff @(posedge clock) begin
    if (srst) begin
      blink_cnt_q <= '0;
      phase_q     <= 1'b1;
    end else if (blink_cnt_q >= BLINK_CYCLES - 1) begin
      blink_cnt_q <= '0;
      phase_q     <= !phase_q;
    end else begin
      blink_cnt_q <= blink_cnt_q + 32'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      ratio_ind_on <= 1'b0;
      avg_ind_on   <= 1'b0;
    end else begin
      ratio_ind_on <= !show_avg && (any_nondef ? phase_q : 1'b1);
      avg_ind_on   <= show_avg && (avg_nondef ? phase_q : 1'b1);
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  a_lock_forces_full: assert property (lock_lost |=> dac_code == jdop_pkg::CODE_FULL)
    else $error("lock loss did not force full code");
  a_notrig_forces_full: assert property (!trig_present |=> dac_code == jdop_pkg::CODE_FULL)
    else $error("missing trigger did not force full code");
  a_nores_full: assert property (!have_res_q |=> dac_code == jdop_pkg::CODE_FULL)
    else $error("output not full before first result");
  a_recall_restart: assert property (recall_go |=> preset_load_message && meas_restart)
    else $error("recall did not restart measurement");
  a_store_marks_slot: assert property (preset_store && idx_ok
    |=> slot_valid_q[$past(preset_index)])
    else $error("stored slot not marked valid");
  a_empty_slot_default: assert property (recall_go && !slot_valid_q[preset_index]
    |=> cfg_active == jdop_pkg::CFG_DEFAULT)
    else $error("empty slot recall did not load defaults");
  a_apply_resume: assert property (cfg_apply && !recall_go |=> meas_restart
    ##1 !disp_valid)
    else $error("apply did not restart measurement");
  a_pf_pass_level: assert property (stage_q && cfg_q.mode == jdop_pkg::JDOP_PASS_FAIL
    && corr_w <= 16'(cfg_q.pass_fail_threshold) && !restart_q
    |=> calc_q == jdop_pkg::CODE_FULL)
    else $error("pass result not at full code");
  a_pf_fail_level: assert property (stage_q && cfg_q.mode == jdop_pkg::JDOP_PASS_FAIL
    && corr_w > 16'(cfg_q.pass_fail_threshold) && !restart_q
    |=> calc_q == jdop_pkg::CODE_ZERO)
    else $error("fail result not at zero code");
  a_prop_saturate: assert property (stage_q && cfg_q.mode == jdop_pkg::JDOP_PROP
    && corr_w >= 16'(cfg_q.range_upper_limit) && !restart_q
    |=> calc_q == jdop_pkg::CODE_FULL)
    else $error("proportional result did not saturate");
  a_prop_floor: assert property (stage_q && cfg_q.mode == jdop_pkg::JDOP_PROP
    && corr_w <= 16'(cfg_q.range_lower_limit) && !restart_q
    |=> calc_q == jdop_pkg::CODE_ZERO)
    else $error("ratio below lower limit not at zero code");
  a_fill_bound: assert property (fill_q <= 4'(jdop_pkg::HIST_N)
    && cfg_q.averaging_count >= jdop_pkg::AVG_MIN)
    else $error("averaging window out of range");
  a_alpha_range: assert property (cfg_q.alpha >= jdop_pkg::ALPHA_MIN
    && cfg_q.alpha <= jdop_pkg::ALPHA_MAX)
    else $error("alpha out of range");
  a_ind_steady: assert property (!any_nondef && !show_avg ##1 !any_nondef && !show_avg
    |-> ratio_ind_on)
    else $error("ratio indicator blinked at defaults");
endmodule
`default_nettype wire

// [hw/jdop_pkg.sv]
`default_nettype none
package jdop_pkg;
  localparam int RATIO_W = 16;
  localparam int JIT_W   = 24;
  localparam int CODE_W  = 12;
  localparam int HIST_N  = 10;
  localparam int SLOTS   = 7;
  localparam logic [CODE_W-1:0] CODE_FULL = 12'hfff;
  localparam logic [CODE_W-1:0] CODE_ZERO = 12'h000;
  localparam logic [13:0] PCT_MAX   = 14'h2710;
  localparam logic [3:0]  AVG_MIN   = 4'h1;
  localparam logic [3:0]  AVG_MAX   = 4'ha;
  localparam logic [16:0] ALPHA_MIN = 17'h00001;
  localparam logic [16:0] ALPHA_MAX = 17'h1869f;
  localparam logic signed [14:0] BETA_MAX = 15'sh270f;
  localparam logic signed [14:0] BETA_MIN = -15'sh270f;
  localparam longint ALPHA_SCALE = 10000;
  localparam longint BETA_SCALE  = 100000;
  localparam longint MILLI_PER_CENTI = 10;
  localparam longint PW_PERIOD_MILLI = 231385;
  localparam int BLINK_TIME_MS = 500;
  localparam int CLK_MHZ       = 100;
  localparam int BLINK_CYCLES  = BLINK_TIME_MS * 1000 * CLK_MHZ;
  typedef enum logic [0:0] {
    JDOP_PROP      = 1'b0,
    JDOP_PASS_FAIL = 1'b1
  } jdop_mode_t;
  typedef enum logic [0:0] {
    JDOP_PULSE_WIDTH_MODE   = 1'b0,
    JDOP_DATA_TO_CLOCK_MODE = 1'b1
  } jdop_func_t;
  typedef struct packed {
    jdop_mode_t         mode;
    logic [13:0]        range_upper_limit;
    logic [13:0]        range_lower_limit;
    logic [13:0]        pass_fail_threshold;
    logic [3:0]         averaging_count;
    logic [16:0]        alpha;
    logic signed [14:0] beta;
  } jdop_cfg_t;
  typedef struct packed {
    logic [RATIO_W-1:0] ratio;
    logic [JIT_W-1:0]   jitter;
  } jdop_meas_t;
  localparam jdop_cfg_t CFG_DEFAULT = '{
    mode: JDOP_PROP, range_upper_limit: 14'h2710, range_lower_limit: 14'h0000,
    pass_fail_threshold: 14'h01f4, averaging_count: 4'h1,
    alpha: 17'h02710, beta: 15'sh0000};
endpackage
`default_nettype wire

// [test/jdop_dac_model.sv]
`timescale 1ns/1ps
`default_nettype none
module jdop_dac_model (
  input  wire logic        clock,
  input  wire logic [11:0] dac_code,
  output int               out_mv
);
  // converter output settles one clock after the code; full code reads as 5 V
  always_ff @(posedge clock) begin
    out_mv <= int'(dac_code) * 5000 / 4095;
  end
endmodule
`default_nettype wire

// [test/jitter_dc_output_processing_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module jitter_dc_output_processing_tb;
  logic                 clock = 1'b0;
  logic                 srst = 1'b1;
  logic                 meas_valid = 1'b0;
  jdop_pkg::jdop_meas_t meas_in = '0;
  logic                 trig_present = 1'b1;
  logic                 lock_lost = 1'b0;
  jdop_pkg::jdop_func_t func_mode = jdop_pkg::JDOP_DATA_TO_CLOCK_MODE;
  logic [3:0]           speed_mult = 4'h1;
  logic [23:0]          clk_period = 24'h186a0;
  logic                 cfg_apply = 1'b0;
  jdop_pkg::jdop_cfg_t  cfg_in = jdop_pkg::CFG_DEFAULT;
  logic                 preset_store = 1'b0;
  logic                 preset_recall = 1'b0;
  logic [2:0]           preset_index = 3'h0;
  logic                 show_avg = 1'b0;
  logic [11:0]          dac_code;
  logic [15:0]          disp_ratio;
  logic [23:0]          disp_jitter;
  logic                 disp_valid, ratio_ind_on, avg_ind_on, preset_load_message, meas_restart;
  jdop_pkg::jdop_cfg_t  cfg_active, cfg_a;
  int                   out_mv, num_errors = 0, n_checks = 0, n;

  // short blink period so a few cycles show several phases
  jdop_output_proc #(.BLINK_CYCLES(4)) dut_u (.clock(clock), .srst(srst),
    .meas_valid(meas_valid), .meas_in(meas_in), .trig_present(trig_present),
    .lock_lost(lock_lost), .func_mode(func_mode), .speed_mult(speed_mult),
    .clk_period(clk_period), .cfg_apply(cfg_apply), .cfg_in(cfg_in),
    .preset_store(preset_store), .preset_recall(preset_recall), .preset_index(preset_index),
    .show_avg(show_avg), .dac_code(dac_code), .disp_ratio(disp_ratio),
    .disp_jitter(disp_jitter), .disp_valid(disp_valid), .ratio_ind_on(ratio_ind_on),
    .avg_ind_on(avg_ind_on), .preset_load_message(preset_load_message),
    .meas_restart(meas_restart), .cfg_active(cfg_active));
  jdop_dac_model conv_u (.clock(clock), .dac_code(dac_code), .out_mv(out_mv));

  always #5 clock = ~clock;

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [95:0] got, input logic [95:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(negedge clock);
  endtask
  // a result lands on dac_code two edges after it is taken
  task automatic send(input logic [15:0] r, input logic [23:0] j);
    meas_in = '{ratio: r, jitter: j};
    meas_valid = 1'b1;
    tick(1);
    meas_valid = 1'b0;
    tick(3);
  endtask
  // wait past the restart cycle, where results would be dropped
  task automatic apply(input jdop_pkg::jdop_cfg_t c);
    cfg_in = c;
    cfg_apply = 1'b1;
    tick(1);
    cfg_apply = 1'b0;
    tick(2);
  endtask
  function automatic jdop_pkg::jdop_cfg_t mk(input logic m, input logic [13:0] hi, lo, th,
      input logic [3:0] na, input logic [16:0] a, input logic signed [14:0] b);
    mk = '{mode: jdop_pkg::jdop_mode_t'(m), range_upper_limit: hi, range_lower_limit: lo,
           pass_fail_threshold: th, averaging_count: na, alpha: a, beta: b};
  endfunction
  task automatic recall(input logic [2:0] i, input jdop_pkg::jdop_cfg_t exp);
    preset_index = i;
    preset_recall = 1'b1;
    tick(1);
    preset_recall = 1'b0;
    chk(cfg_active, exp);
    chk(preset_load_message, 1'b1);
    chk(meas_restart, 1'b1);
    tick(1);
    chk(disp_valid, 1'b0);
    tick(1);
    chk(dac_code, jdop_pkg::CODE_FULL);
  endtask
  task automatic blink(input logic which, output int cnt);
    logic prev;
    cnt = 0;
    prev = which ? avg_ind_on : ratio_ind_on;
    repeat (12) begin
      tick(1);
      if ((which ? avg_ind_on : ratio_ind_on) !== prev) cnt++;
      prev = which ? avg_ind_on : ratio_ind_on;
    end
  endtask

  // whole sequence needs well under 1000 cycles
  initial begin
    #200000;
    num_errors++;
    wrap_up();
  end

  initial begin
    tick(8);
    srst = 1'b0;
    chk(dac_code, jdop_pkg::CODE_FULL);
    chk(cfg_active, jdop_pkg::CFG_DEFAULT);
    $display("test reset done");
    apply(mk(1'b0, 14'h09c4, 14'h01f4, 14'h01f4, 4'h1, 17'h02710, 15'sh0000));
    send(16'h05dc, 24'h0); chk(dac_code, 12'h7ff);
    chk(disp_ratio, 16'h05dc);
    send(16'h01f4, 24'h0); chk(dac_code, jdop_pkg::CODE_ZERO);
    send(16'h09c4, 24'h0); chk(dac_code, jdop_pkg::CODE_FULL);
    send(16'h0bb8, 24'h0); chk(dac_code, jdop_pkg::CODE_FULL);
    send(16'h0064, 24'h0); chk(dac_code, jdop_pkg::CODE_ZERO);
    $display("test proportional done");
    apply(mk(1'b1, 14'h09c4, 14'h01f4, 14'h01f4, 4'h1, 17'h02710, 15'sh0000));
    send(16'h01f4, 24'h0); chk(dac_code, jdop_pkg::CODE_FULL);
    send(16'h01f5, 24'h0); chk(dac_code, jdop_pkg::CODE_ZERO);
    trig_present = 1'b0;
    tick(2); chk(dac_code, jdop_pkg::CODE_FULL);
    chk(out_mv, 32'h1388);
    trig_present = 1'b1;
    tick(2); chk(dac_code, jdop_pkg::CODE_ZERO);
    lock_lost = 1'b1;
    tick(2); chk(dac_code, jdop_pkg::CODE_FULL);
    lock_lost = 1'b0;
    $display("test pass fail done");
    apply(mk(1'b0, 14'h2710, 14'h0000, 14'h01f4, 4'h2, 17'h02710, 15'sh0000));
    send(16'h03e8, 24'h0); chk(disp_ratio, 16'h03e8);
    send(16'h07d0, 24'h0); chk(disp_ratio, 16'h05dc);
    send(16'h0bb8, 24'h0); chk(disp_ratio, 16'h09c4);
    chk(dac_code, 12'h3ff);
    show_avg = 1'b1;
    blink(1'b1, n); chk(n > 1, 1'b1);
    $display("test average done");
    apply(mk(1'b0, 14'h2710, 14'h0000, 14'h01f4, 4'h1, 17'h04e20, 15'sh03e8));
    send(16'h03e8, 24'h001388); chk(disp_ratio, 16'h0834);
    chk(disp_jitter, 24'h002af8);
    func_mode = jdop_pkg::JDOP_PULSE_WIDTH_MODE;
    speed_mult = 4'h5;
    send(16'h03e8, 24'h001388); chk(disp_jitter, 24'h0028de);
    blink(1'b1, n); chk(n, 32'h0);
    show_avg = 1'b0;
    blink(1'b0, n); chk(n > 1, 1'b1);
    apply(jdop_pkg::CFG_DEFAULT);
    send(16'h01f4, 24'h0);
    blink(1'b0, n); chk(n, 32'h0);
    apply(mk(1'b0, 14'h3fff, 14'h0000, 14'h3fff, 4'hf, 17'h1ffff, 15'sh3fff));
    chk(cfg_active.range_upper_limit, 14'h2710);
    chk(cfg_active.pass_fail_threshold, 14'h2710);
    chk(cfg_active.averaging_count, 4'ha);
    chk(cfg_active.alpha, 17'h1869f);
    chk(cfg_active.beta, 15'sh270f);
    apply(mk(1'b0, 14'h2710, 14'h0000, 14'h01f4, 4'h0, 17'h00000, -15'sh3fff));
    chk(cfg_active.averaging_count, 4'h1);
    chk(cfg_active.alpha, 17'h00001);
    chk(cfg_active.beta, -15'sh270f);
    $display("test correction done");
    cfg_a = mk(1'b1, 14'h07d0, 14'h0064, 14'h02bc, 4'h3, 17'h03039, -15'sh0032);
    apply(cfg_a);
    chk(cfg_active, cfg_a);
    preset_index = 3'h6;
    preset_store = 1'b1;
    tick(1);
    preset_store = 1'b0;
    apply(jdop_pkg::CFG_DEFAULT);
    send(16'h0064, 24'h0);
    chk(dac_code, 12'h028);
    recall(3'h6, cfg_a);
    send(16'h03e8, 24'h0);
    chk(disp_ratio, 16'h04cd);
    chk(dac_code, jdop_pkg::CODE_ZERO);
    recall(3'h5, jdop_pkg::CFG_DEFAULT);
    $display("test recall done");
    wrap_up();
  end
endmodule
`default_nettype wire
